// file: verilog/fdc_status_pkg.sv
// Constants and types for the result status and reset block
package fdc_status_pkg;

  typedef enum logic [2:0] {
    CMD_OTHER         = 3'h0,
    CMD_READ_DATA     = 3'h1,
    CMD_READ_DELETED  = 3'h2,
    CMD_WRITE_DATA    = 3'h3,
    CMD_WRITE_DELETED = 3'h4,
    CMD_FORMAT        = 3'h5,
    CMD_READ_ID       = 3'h6,
    CMD_READ_TRACK    = 3'h7
  } cmd_kind_t;

  typedef enum logic [1:0] {
    SEL_ERR_ONE = 2'h0,
    SEL_ERR_TWO = 2'h1,
    SEL_DRIVE   = 2'h2,
    SEL_NONE    = 2'h3
  } res_sel_t;

  // Flag positions, error byte one at 0..7, error byte two at 8..15
  localparam int unsigned E1_END_TRACK  = 7;
  localparam int unsigned E1_CRC_ANY    = 5;
  localparam int unsigned E1_LATE       = 4;
  localparam int unsigned E1_MISSING    = 2;
  localparam int unsigned E1_WR_BLOCKED = 1;
  localparam int unsigned E1_NO_ID_SYNC = 0;
  localparam int unsigned E2_CTRL_MARK  = 6;
  localparam int unsigned E2_CRC_PAY    = 5;
  localparam int unsigned E2_TRACK_MIS  = 4;
  localparam int unsigned E2_BAD_TRACK  = 1;
  localparam int unsigned E2_PAY_SYNC   = 0;
  localparam int unsigned E2_BASE       = 8;
  localparam int unsigned D_WP          = 6;
  localparam int unsigned D_OUTER_TRACK_INPUT        = 4;
  localparam int unsigned D_SIDE        = 2;
  localparam int unsigned D_UNIT_LO     = 0;

  localparam logic [15:0] FLAG_USED   = 16'h73B7;
  localparam logic [7:0]  E1_FIXED    = 8'h00;
  localparam logic [7:0]  E2_FIXED    = 8'h00;
  localparam logic [7:0]  DRV_FIXED   = 8'h28;
  localparam logic [7:0]  BAD_TRACK   = 8'hFF;
  localparam logic [1:0]  INDEX_LIMIT = 2'h2;
  localparam logic [1:0]  IDX_STEP    = 2'h1;
  localparam logic        OCR_RST_POR = 1'b1;
  localparam logic [7:0]  RESULT_POR  = 8'h00;
  localparam logic [7:0]  SPEC_POR    = 8'h00;

endpackage

// file: verilog/sticky_flag.sv
// One sticky status flag, set wins over clear
`timescale 1ns/1ps
module sticky_flag (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Control
  input  wire logic set,
  input  wire logic clr,
  // State
  output logic      q_ff
);

  typedef struct packed {
    logic q;
  } flag_st_t;

  flag_st_t st_ff;
  flag_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (set) begin
      nxt_st.q = 1'b1;
    end else if (clr) begin
      nxt_st.q = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_ff = st_ff.q;

endmodule

// file: verilog/reset_ctl.sv
// Reset source merging and power-down exit
`timescale 1ns/1ps
module reset_ctl (
  // Clock and power-on reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Reset sources
  input  wire logic reset_pin,
  input  wire logic ocr_wr,
  input  wire logic ocr_reset_bit,
  input  wire logic rate_wr,
  input  wire logic rate_reset_bit,
  // Power-down request
  input  wire logic power_down_req,
  // State
  output logic      core_reset_ff,
  output logic      ocr_reset_ff,
  output logic      power_down_ff,
  output logic      release_ff
);

  typedef struct packed {
    logic ocr;
    logic rate;
    logic core;
    logic pd;
    logic rel;
  } rst_st_t;

  rst_st_t st_ff;
  rst_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.rate = 1'b0;
    if (reset_pin) begin
      nxt_st.ocr = 1'b1;
    end else if (ocr_wr) begin
      nxt_st.ocr = ocr_reset_bit;
    end
    if (rate_wr && rate_reset_bit) begin
      nxt_st.rate = 1'b1;
    end
    // Control bit holds the core even after the rate pulse ends
    nxt_st.core = nxt_st.ocr | nxt_st.rate | reset_pin;
    if (nxt_st.core) begin
      nxt_st.pd = 1'b0;
    end else if (power_down_req) begin
      nxt_st.pd = 1'b1;
    end
    nxt_st.rel = st_ff.core & ~nxt_st.core;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff      <= '0;
      st_ff.ocr  <= fdc_status_pkg::OCR_RST_POR;
      st_ff.core <= fdc_status_pkg::OCR_RST_POR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign core_reset_ff = st_ff.core;
  assign ocr_reset_ff  = st_ff.ocr;
  assign power_down_ff = st_ff.pd;
  assign release_ff    = st_ff.rel;

  property p_pin_sets_ocr;
    @(posedge clk_sys) disable iff (!rst_b)
    reset_pin |=> (ocr_reset_ff && core_reset_ff);
  endproperty
  a_pin_sets_ocr: assert property (p_pin_sets_ocr) else $error("pin reset left ocr bit clear");

  property p_ocr_holds;
    @(posedge clk_sys) disable iff (!rst_b)
    (ocr_reset_ff && !ocr_wr) |=> (ocr_reset_ff && core_reset_ff);
  endproperty
  a_ocr_holds: assert property (p_ocr_holds) else $error("ocr reset bit dropped alone");

  property p_rate_self_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    (rate_wr && rate_reset_bit && !ocr_reset_ff && !reset_pin && !ocr_wr) ##1
      (!rate_wr && !reset_pin && !ocr_wr) |=> !core_reset_ff;
  endproperty
  a_rate_self_clear: assert property (p_rate_self_clear) else $error("rate reset stuck");

  property p_reset_wakes;
    @(posedge clk_sys) disable iff (!rst_b)
    (reset_pin || (rate_wr && rate_reset_bit)) |=> !power_down_ff;
  endproperty
  a_reset_wakes: assert property (p_reset_wakes) else $error("power-down survived reset");

endmodule

// file: verilog/fdc_result_status.sv
// Result status bytes, error flag capture and reset handling
`timescale 1ns/1ps
module fdc_result_status (
  // Clock and power-on reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  // Reset sources
  input  wire logic                      reset_pin,
  input  wire logic                      ocr_wr,
  input  wire logic                      ocr_reset_bit,
  input  wire logic                      rate_wr,
  input  wire logic                      rate_reset_bit,
  input  wire logic                      power_down_req,
  // Command framing
  input  wire logic                      cmd_start,
  input  wire fdc_status_pkg::cmd_kind_t cmd_kind,
  input  wire logic                      cmd_end,
  input  wire logic                      transfer_count_end,
  // Execution events
  input  wire logic                      sector_past_end,
  input  wire logic                      crc_err_id,
  input  wire logic                      crc_err_data,
  input  wire logic                      service_late,
  input  wire logic                      sector_not_found,
  input  wire logic                      id_read_err,
  input  wire logic                      track_seq_err,
  input  wire logic                      id_mark_found,
  input  wire logic                      data_mark_found,
  input  wire logic                      data_mark_deleted,
  input  wire logic                      data_mark_missing,
  input  wire logic                      id_valid,
  input  wire logic [7:0]                id_track,
  input  wire logic [7:0]                cur_cylinder,
  // Drive cable
  input  wire logic                      write_protect_pin,
  input  wire logic                      outer_track_input,
  input  wire logic                      index_pulse_pin,
  input  wire logic                      side_select_output,
  input  wire logic [1:0]                unit_select_pins,
  // Configure and specify values
  input  wire logic                      cfg_wr,
  input  wire logic                      cfg_poll_disable,
  input  wire logic                      spec_wr,
  input  wire logic [7:0]                spec_data,
  // Result phase read
  input  wire logic                      result_rd,
  input  wire fdc_status_pkg::res_sel_t  result_sel,
  // Outputs
  output logic [7:0]                     result_data_ff,
  output logic [7:0]                     spec_value_ff,
  output logic                           cmd_busy_ff,
  output logic                           poll_enable_ff,
  output logic                           core_reset_ff,
  output logic                           ocr_reset_ff,
  output logic                           power_down_ff
);

  typedef struct packed {
    fdc_status_pkg::cmd_kind_t kind;
    logic                      busy;
    logic                      tc_seen;
    logic [1:0]                idx_cnt;
    logic                      poll_dis;
    logic                      poll_en;
    logic [7:0]                spec;
    logic [7:0]                result;
  } main_st_t;

  main_st_t    st_ff;
  main_st_t    nxt_st;
  logic        release_ff;
  logic        start_ok;
  logic        live;
  logic        is_read;
  logic        is_data;
  logic        is_write;
  logic        trk_diff;
  logic [15:0] flag_set;
  logic [15:0] flag_q;
  logic        flag_clr;
  logic [7:0]  err_one;
  logic [7:0]  err_two;
  logic [7:0]  drive_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources

  reset_ctl u_reset_ctl (
    .clk_sys        (clk_sys),
    .rst_b          (rst_b),
    .reset_pin      (reset_pin),
    .ocr_wr         (ocr_wr),
    .ocr_reset_bit  (ocr_reset_bit),
    .rate_wr        (rate_wr),
    .rate_reset_bit (rate_reset_bit),
    .power_down_req (power_down_req),
    .core_reset_ff  (core_reset_ff),
    .ocr_reset_ff   (ocr_reset_ff),
    .power_down_ff  (power_down_ff),
    .release_ff     (release_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  // Commands are refused while the core is held in reset
  assign start_ok = cmd_start & ~core_reset_ff;
  assign live     = st_ff.busy & ~core_reset_ff;
  assign is_read  = (st_ff.kind == fdc_status_pkg::CMD_READ_DATA) ||
                    (st_ff.kind == fdc_status_pkg::CMD_READ_DELETED);
  assign is_data  = is_read ||
                    (st_ff.kind == fdc_status_pkg::CMD_WRITE_DATA) ||
                    (st_ff.kind == fdc_status_pkg::CMD_WRITE_DELETED);
  assign is_write = (st_ff.kind == fdc_status_pkg::CMD_WRITE_DATA) ||
                    (st_ff.kind == fdc_status_pkg::CMD_WRITE_DELETED) ||
                    (st_ff.kind == fdc_status_pkg::CMD_FORMAT);
  assign trk_diff = id_valid && (id_track != cur_cylinder);
  assign flag_clr = start_ok | core_reset_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Flag set terms

  always_comb begin
    flag_set = '0;
    flag_set[fdc_status_pkg::E1_END_TRACK] =
      sector_past_end ||
      (cmd_end && is_data && !st_ff.tc_seen && !transfer_count_end);
    flag_set[fdc_status_pkg::E1_CRC_ANY] = crc_err_id || crc_err_data;
    flag_set[fdc_status_pkg::E1_LATE]    = service_late;
    flag_set[fdc_status_pkg::E1_MISSING] =
      (sector_not_found && is_read) ||
      (id_read_err && (st_ff.kind == fdc_status_pkg::CMD_READ_ID)) ||
      (track_seq_err && (st_ff.kind == fdc_status_pkg::CMD_READ_TRACK));
    flag_set[fdc_status_pkg::E1_WR_BLOCKED] = write_protect_pin && is_write;
    flag_set[fdc_status_pkg::E1_NO_ID_SYNC] =
      data_mark_missing ||
      (index_pulse_pin && !id_mark_found &&
       (st_ff.idx_cnt == fdc_status_pkg::INDEX_LIMIT - fdc_status_pkg::IDX_STEP));
    flag_set[fdc_status_pkg::E2_BASE + fdc_status_pkg::E2_CTRL_MARK] =
      data_mark_found &&
      (((st_ff.kind == fdc_status_pkg::CMD_READ_DATA) && data_mark_deleted) ||
       ((st_ff.kind == fdc_status_pkg::CMD_READ_DELETED) && !data_mark_deleted));
    flag_set[fdc_status_pkg::E2_BASE + fdc_status_pkg::E2_CRC_PAY] = crc_err_data;
    flag_set[fdc_status_pkg::E2_BASE + fdc_status_pkg::E2_TRACK_MIS] = trk_diff;
    flag_set[fdc_status_pkg::E2_BASE + fdc_status_pkg::E2_BAD_TRACK] =
      trk_diff && (id_track == fdc_status_pkg::BAD_TRACK);
    flag_set[fdc_status_pkg::E2_BASE + fdc_status_pkg::E2_PAY_SYNC] =
      data_mark_missing;
    // Events outside a live command are dropped, reset aborts everything
    flag_set = flag_set & fdc_status_pkg::FLAG_USED & {16{live}};
  end

  // Only documented flags get storage
  for (genvar i = 0; i < 16; i++) begin : g_flag
    if (fdc_status_pkg::FLAG_USED[i]) begin : g_used
      sticky_flag u_flag (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .set     (flag_set[i]),
        .clr     (flag_clr),
        .q_ff    (flag_q[i])
      );
    end else begin : g_fixed
      assign flag_q[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte assembly

  always_comb begin
    err_one    = flag_q[7:0] | fdc_status_pkg::E1_FIXED;
    err_two    = flag_q[15:8] | fdc_status_pkg::E2_FIXED;
    drive_byte = fdc_status_pkg::DRV_FIXED;
    drive_byte[fdc_status_pkg::D_WP]   = write_protect_pin;
    drive_byte[fdc_status_pkg::D_OUTER_TRACK_INPUT] = outer_track_input;
    drive_byte[fdc_status_pkg::D_SIDE] = side_select_output;
    drive_byte[fdc_status_pkg::D_UNIT_LO +: 2] = unit_select_pins;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command, polling and result state

  always_comb begin
    nxt_st = st_ff;
    if (start_ok) begin
      nxt_st.kind    = cmd_kind;
      nxt_st.busy    = 1'b1;
      nxt_st.tc_seen = 1'b0;
      nxt_st.idx_cnt = '0;
    end else if (live) begin
      if (transfer_count_end) begin
        nxt_st.tc_seen = 1'b1;
      end
      if (id_mark_found) begin
        nxt_st.idx_cnt = '0;
      end else if (index_pulse_pin && (st_ff.idx_cnt != fdc_status_pkg::INDEX_LIMIT)) begin
        nxt_st.idx_cnt = 2'(st_ff.idx_cnt + fdc_status_pkg::IDX_STEP);
      end
      if (cmd_end) begin
        nxt_st.busy = 1'b0;
      end
    end
    if (cfg_wr && !core_reset_ff) begin
      nxt_st.poll_dis = cfg_poll_disable;
    end
    if (spec_wr && !core_reset_ff) begin
      nxt_st.spec = spec_data;
    end
    if (result_rd) begin
      case (result_sel)
        fdc_status_pkg::SEL_ERR_ONE: nxt_st.result = err_one;
        fdc_status_pkg::SEL_ERR_TWO: nxt_st.result = err_two;
        fdc_status_pkg::SEL_DRIVE:   nxt_st.result = drive_byte;
        default:                     nxt_st.result = fdc_status_pkg::RESULT_POR;
      endcase
    end
    if (core_reset_ff) begin
      // Writes in flight are cut short; the medium may hold a bad CRC
      nxt_st.busy     = 1'b0;
      nxt_st.tc_seen  = 1'b0;
      nxt_st.idx_cnt  = '0;
      nxt_st.kind     = fdc_status_pkg::CMD_OTHER;
      nxt_st.poll_dis = 1'b0;
      nxt_st.result   = fdc_status_pkg::RESULT_POR;
    end
    // Specify value survives every core reset, only power-on clears it
    nxt_st.poll_en = ~core_reset_ff & ~nxt_st.poll_dis;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff      <= '0;
      st_ff.spec <= fdc_status_pkg::SPEC_POR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign result_data_ff = st_ff.result;
  assign spec_value_ff  = st_ff.spec;
  assign cmd_busy_ff    = st_ff.busy;
  assign poll_enable_ff = st_ff.poll_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_end_track;
    @(posedge clk_sys) disable iff (!rst_b)
    (live && cmd_end && is_data && !st_ff.tc_seen && !transfer_count_end && !cmd_start)
      |=> flag_q[fdc_status_pkg::E1_END_TRACK];
  endproperty
  a_end_track: assert property (p_end_track) else $error("end of track flag missing");

  property p_crc_both;
    @(posedge clk_sys) disable iff (!rst_b)
    (live && crc_err_data) |=> (flag_q[fdc_status_pkg::E1_CRC_ANY] && flag_q[13]);
  endproperty
  a_crc_both: assert property (p_crc_both) else $error("data CRC flags missing");

  property p_wp_block;
    @(posedge clk_sys) disable iff (!rst_b)
    (live && is_write && write_protect_pin) |=> flag_q[fdc_status_pkg::E1_WR_BLOCKED];
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write block flag missing");

  // Index counter replaces a long repetition, so its first step is checked too
  property p_index_step;
    @(posedge clk_sys) disable iff (!rst_b)
    (live && !start_ok && !id_mark_found && index_pulse_pin && st_ff.idx_cnt == 2'h0)
      |=> (st_ff.idx_cnt == fdc_status_pkg::IDX_STEP);
  endproperty
  a_index_step: assert property (p_index_step) else $error("index pulse not counted");

  property p_two_index;
    @(posedge clk_sys) disable iff (!rst_b)
    (live && !id_mark_found && index_pulse_pin && st_ff.idx_cnt == fdc_status_pkg::IDX_STEP)
      |=> flag_q[fdc_status_pkg::E1_NO_ID_SYNC];
  endproperty
  a_two_index: assert property (p_two_index) else $error("missing ID mark flag");

  property p_bad_track;
    @(posedge clk_sys) disable iff (!rst_b)
    (live && id_valid && id_track == 8'hFF && cur_cylinder != 8'hFF)
      |=> (flag_q[9] && flag_q[12]);
  endproperty
  a_bad_track: assert property (p_bad_track) else $error("bad track flags missing");

  property p_drive_byte;
    @(posedge clk_sys) disable iff (!rst_b)
    (result_rd && result_sel == fdc_status_pkg::SEL_DRIVE && !core_reset_ff) |=>
      (result_data_ff[5] && result_data_ff[3] && !result_data_ff[7] &&
       result_data_ff[6] == $past(write_protect_pin) &&
       result_data_ff[1:0] == $past(unit_select_pins));
  endproperty
  a_drive_byte: assert property (p_drive_byte) else $error("drive status byte wrong");

  property p_reset_clears;
    @(posedge clk_sys) disable iff (!rst_b)
    core_reset_ff |=> (flag_q == 16'h0000 && !cmd_busy_ff && !poll_enable_ff);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state behind");

  property p_start_clears;
    @(posedge clk_sys) disable iff (!rst_b)
    (start_ok && !live) |=> (flag_q == 16'h0000);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("flags survived new command");

  property p_spec_kept;
    @(posedge clk_sys) disable iff (!rst_b)
    (reset_pin && !spec_wr) |=> $stable(spec_value_ff);
  endproperty
  a_spec_kept: assert property (p_spec_kept) else $error("specify value lost on pin reset");

  property p_poll_start;
    @(posedge clk_sys) disable iff (!rst_b)
    (release_ff && !cfg_wr) |=> poll_enable_ff;
  endproperty
  a_poll_start: assert property (p_poll_start) else $error("polling not started");

endmodule

// file: tb/drive_model.sv
// Behavioural floppy drive cable model
`timescale 1ns/1ps
module drive_model (
  // Clock
  input  wire logic clk_sys,
  // Bench controls
  input  wire logic wp_set,
  input  wire logic trk_set,
  input  wire logic idx_req,
  // Cable levels
  output logic      write_protect_pin,
  output logic      outer_track_input,
  output logic      index_pulse_pin
);
  // One cycle of cable lag, so pins never move on the bench's own edge
  always_ff @(posedge clk_sys) begin
    write_protect_pin <= wp_set;
    outer_track_input <= trk_set;
    index_pulse_pin   <= idx_req;
  end
endmodule

// file: tb/test_floppy_result_status_and_reset.sv
// Self-checking bench for the result status and reset block
`timescale 1ns/1ps
module test_floppy_result_status_and_reset;
  logic clk_sys=0, rst_b=0, reset_pin=0, ocr_wr=0, ocr_reset_bit=0, rate_wr=0, cfg_wr=0;
  logic rate_reset_bit=0, power_down_req=0, cmd_start=0, cmd_end=0, transfer_count_end=0;
  logic data_mark_deleted=0, side_select_output=0, cfg_poll_disable=0, spec_wr=0;
  logic result_rd=0, wp_set=0, trk_set=0, idx_req=0, tc_on=1;
  logic write_protect_pin, outer_track_input, index_pulse_pin;
  logic cmd_busy_ff, poll_enable_ff, core_reset_ff, ocr_reset_ff, power_down_ff;
  logic [10:0] ev='0;
  logic [7:0] id_track=0, cur_cylinder=0, spec_data=0, result_data_ff, spec_value_ff;
  logic [1:0] unit_select_pins=0;
  fdc_status_pkg::cmd_kind_t cmd_kind=fdc_status_pkg::CMD_OTHER;
  fdc_status_pkg::res_sel_t result_sel=fdc_status_pkg::SEL_NONE;
  int failures=0, checks_done=0, cyc=0;
  drive_model drv_u (.clk_sys, .wp_set, .trk_set, .idx_req, .write_protect_pin,
    .outer_track_input, .index_pulse_pin);
  fdc_result_status dut_u (.clk_sys, .rst_b, .reset_pin, .ocr_wr, .ocr_reset_bit, .rate_wr,
    .rate_reset_bit, .power_down_req, .cmd_start, .cmd_kind, .cmd_end, .transfer_count_end,
    .sector_past_end(ev[0]), .crc_err_id(ev[1]), .crc_err_data(ev[2]), .service_late(ev[3]),
    .sector_not_found(ev[4]), .id_read_err(ev[5]), .track_seq_err(ev[6]),
    .id_mark_found(ev[7]), .data_mark_found(ev[8]), .data_mark_deleted,
    .data_mark_missing(ev[9]), .id_valid(ev[10]), .id_track, .cur_cylinder,
    .write_protect_pin, .outer_track_input, .index_pulse_pin, .side_select_output,
    .unit_select_pins, .cfg_wr, .cfg_poll_disable, .spec_wr, .spec_data, .result_rd,
    .result_sel, .result_data_ff, .spec_value_ff, .cmd_busy_ff, .poll_enable_ff,
    .core_reset_ff, .ocr_reset_ff, .power_down_ff);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tk(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (e !== g) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] drv_exp();
    return {1'b0, wp_set, 1'b1, trk_set, 1'b1, side_select_output, unit_select_pins};
  endfunction
  task automatic rd(logic [1:0] s, logic [7:0] e);
    result_rd = 1;
    result_sel = fdc_status_pkg::res_sel_t'(s);
    tk();
    result_rd = 0;
    chk("result_byte", e, result_data_ff);
    // Idle edge so a following read never re-raises the strobe at once
    tk();
  endtask
  task automatic hit(int i);
    ev[i] = 1;
    tk();
    ev = '0;
  endtask
  task automatic ctl(logic o, logic r, logic b);
    ocr_wr = o;
    rate_wr = r;
    ocr_reset_bit = b;
    rate_reset_bit = b;
    tk();
    ocr_wr = 0;
    rate_wr = 0;
  endtask
  // Index 11 stands for two index pulses with no ID mark between
  task automatic run(logic [2:0] k, int i, logic [7:0] e1, logic [7:0] e2);
    cmd_kind = fdc_status_pkg::cmd_kind_t'(k);
    cmd_start = 1;
    tk();
    cmd_start = 0;
    tk();
    if (i > 10) repeat (2) begin
      idx_req = 1;
      tk();
      idx_req = 0;
      tk();
    end
    else if (i >= 0) hit(i);
    tk(2);
    cmd_end = 1;
    transfer_count_end = tc_on;
    tk();
    cmd_end = 0;
    transfer_count_end = 0;
    rd(2'h0, e1);
    rd(2'h1, e2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h40C7));
    tk(10);
    rst_b = 1;
    chk("ocr_reset", 8'h01, {7'h00, ocr_reset_ff});
    ctl(1, 0, 0);
    tk();
    chk("poll", 8'h01, {7'h00, poll_enable_ff});
    cur_cylinder = 8'($urandom_range(1, 254));
    id_track = cur_cylinder - 8'h01;
    hit(2);
    run(3'h1, -1, 8'h00, 8'h00);
    run(3'h1, 0, 8'h80, 8'h00);
    run(3'h2, 1, 8'h20, 8'h00);
    run(3'h1, 2, 8'h20, 8'h20);
    run(3'h3, 3, 8'h10, 8'h00);
    run(3'h2, 4, 8'h04, 8'h00);
    run(3'h6, 5, 8'h04, 8'h00);
    run(3'h7, 6, 8'h04, 8'h00);
    run(3'h1, 9, 8'h01, 8'h01);
    run(3'h1, 11, 8'h01, 8'h00);
    run(3'h1, 10, 8'h00, 8'h10);
    id_track = 8'hFF;
    run(3'h2, 10, 8'h00, 8'h12);
    id_track = cur_cylinder;
    run(3'h1, 10, 8'h00, 8'h00);
    data_mark_deleted = 1;
    run(3'h1, 8, 8'h00, 8'h40);
    run(3'h2, 8, 8'h00, 8'h00);
    data_mark_deleted = 0;
    run(3'h2, 8, 8'h00, 8'h40);
    tc_on = 0;
    run(3'h4, -1, 8'h80, 8'h00);
    run(3'h0, -1, 8'h00, 8'h00);
    tc_on = 1;
    wp_set = 1;
    run(3'h5, -1, 8'h02, 8'h00);
    run(3'h1, -1, 8'h00, 8'h00);
    repeat (6) begin
      {wp_set, trk_set, side_select_output, unit_select_pins} = 5'($urandom);
      tk(2);
      rd(2'h2, drv_exp());
    end
    wp_set = 0;
    rd(2'h3, 8'h00);
    spec_data = 8'($urandom);
    spec_wr = 1;
    cfg_wr = 1;
    cfg_poll_disable = 1;
    tk();
    spec_wr = 0;
    cfg_wr = 0;
    tk();
    chk("poll", 8'h00, {7'h00, poll_enable_ff});
    cmd_kind = fdc_status_pkg::CMD_WRITE_DATA;
    cmd_start = 1;
    tk();
    cmd_start = 0;
    hit(3);
    ctl(0, 1, 1);
    chk("core_reset", 8'h01, {7'h00, core_reset_ff});
    tk();
    chk("busy", 8'h00, {7'h00, cmd_busy_ff});
    chk("core_reset", 8'h00, {7'h00, core_reset_ff});
    tk(2);
    chk("poll", 8'h01, {7'h00, poll_enable_ff});
    rd(2'h0, 8'h00);
    power_down_req = 1;
    tk(2);
    chk("power_down", 8'h01, {7'h00, power_down_ff});
    power_down_req = 0;
    reset_pin = 1;
    tk();
    reset_pin = 0;
    chk("pd_ocr", 8'h01, {6'h00, power_down_ff, ocr_reset_ff});
    ctl(0, 1, 1);
    tk(2);
    chk("core_reset", 8'h01, {7'h00, core_reset_ff});
    chk("spec", spec_data, spec_value_ff);
    rd(2'h2, 8'h00);
    end_of_test();
  end
endmodule
